// ### src/plldc_pkg.sv
package plldc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_LOCK_CFG  = 10'h018;
  localparam logic [9:0] IDX_SYNC_DLY  = 10'h019;
  localparam logic [9:0] IDX_ABL_CFG   = 10'h020;
  localparam logic [9:0] IDX_IRQ_STAT  = 10'h021;
  localparam logic [9:0] IDX_IRQ_MASK  = 10'h022;
  localparam logic [9:0] IDX_LOCK_STAT = 10'h023;

  // Field positions
  localparam int RUN_SEL_HI  = 6;
  localparam int RUN_SEL_LO  = 5;
  localparam int WIN_RANGE_B = 4;
  localparam int LD_DIS_B    = 3;
  localparam int SYNC_HI     = 7;
  localparam int SYNC_LO     = 6;
  localparam int RDLY_HI     = 5;
  localparam int RDLY_LO     = 3;
  localparam int FDLY_HI     = 2;
  localparam int FDLY_LO     = 0;
  localparam int IRQ_LOCK_B  = 0;
  localparam int IRQ_LOSS_B  = 1;

  // Reset values
  localparam logic [7:0] LOCK_CFG_RST = 8'h00;
  localparam logic [7:0] SYNC_DLY_RST = 8'h00;
  localparam logic [1:0] ABL_RST      = 2'h0;

  // Sync pin response codes
  localparam logic [1:0] SYNC_ASYNC = 2'h1;
  localparam logic [1:0] SYNC_SYNC  = 2'h2;

  // Antibacklash widths in picoseconds
  localparam logic [12:0] ABL_PS_2P9 = 13'h0B54;
  localparam logic [12:0] ABL_PS_1P3 = 13'h0514;
  localparam logic [12:0] ABL_PS_6P0 = 13'h1770;

  // Consecutive cycles to lock
  localparam logic [7:0] RUN_5   = 8'h05;
  localparam logic [7:0] RUN_16  = 8'h10;
  localparam logic [7:0] RUN_64  = 8'h40;
  localparam logic [7:0] RUN_255 = 8'hFF;

  // Window and loss thresholds in clock cycles
  localparam logic [7:0] WIN_HI  = 8'h03;
  localparam logic [7:0] WIN_LO  = 8'h01;
  localparam logic [7:0] LOSS_HI = 8'h06;
  localparam logic [7:0] LOSS_LO = 8'h02;
  localparam logic [7:0] GAP_MAX = 8'hFF;

  typedef enum logic [2:0] {
    GAP_IDLE     = 3'b001,
    GAP_WAIT_FB  = 3'b010,
    GAP_WAIT_REF = 3'b100
  } plldc_gap_t;
endpackage

// ### src/plldc_top.sv
// The APB register port was chosen for this implementation.
module plldc_top
  import plldc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic      [31:0] prdata_o,
  output logic             pslverr_o,
  // Detector inputs, one-cycle edge pulses
  input  wire logic        ref_edge_i,
  input  wire logic        fb_edge_i,
  // Sync pin, active high
  input  wire logic        sync_i,
  // Analog controls
  output logic       [1:0] abl_sel_o,
  output logic      [12:0] abl_width_ps_o,
  output logic       [2:0] ref_delay_o,
  output logic       [2:0] fb_delay_o,
  // Divider resets, lock and interrupt
  output logic             div_async_rst_o,
  output logic             div_sync_rst_o,
  output logic             lock_flag_o,
  output logic             irq_o
);

  function automatic logic [12:0] abl_ps(input logic [1:0] code);
    case (code)
      2'h1:    abl_ps = ABL_PS_1P3;
      2'h2:    abl_ps = ABL_PS_6P0;
      default: abl_ps = ABL_PS_2P9;
    endcase
  endfunction

  function automatic logic [7:0] run_target(input logic [1:0] code);
    case (code)
      2'h1:    run_target = RUN_16;
      2'h2:    run_target = RUN_64;
      2'h3:    run_target = RUN_255;
      default: run_target = RUN_5;
    endcase
  endfunction

  logic [7:0] lock_cfg;
  logic [7:0] sync_dly;
  logic [1:0] abl_cfg;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [7:0] run_cnt;
  logic [7:0] gap_cnt;
  logic       sync_q;
  plldc_gap_t gap_state;

  // Bus decode
  wire        idx_ok    = (paddr_i[1:0] == 2'h0);
  wire  [9:0] idx       = paddr_i[11:2];
  wire        setup     = psel_i && !penable_i;
  wire        wr_acc    = psel_i && penable_i && pwrite_i;
  wire        hit_lock  = idx_ok && (idx == IDX_LOCK_CFG);
  wire        hit_sync  = idx_ok && (idx == IDX_SYNC_DLY);
  wire        hit_abl   = idx_ok && (idx == IDX_ABL_CFG);
  wire        hit_stat  = idx_ok && (idx == IDX_IRQ_STAT);
  wire        hit_mask  = idx_ok && (idx == IDX_IRQ_MASK);
  wire        hit_lst   = idx_ok && (idx == IDX_LOCK_STAT);
  wire        hit_any   = hit_lock | hit_sync | hit_abl | hit_stat | hit_mask | hit_lst;
  wire [31:0] rd_mux    = hit_lock ? {24'h00_0000, lock_cfg} :
                          hit_sync ? {24'h00_0000, sync_dly} :
                          hit_abl  ? {30'h0000_0000, abl_cfg} :
                          hit_stat ? {30'h0000_0000, irq_stat} :
                          hit_mask ? {30'h0000_0000, irq_mask} :
                          hit_lst  ? {23'h00_0000, run_cnt, lock_flag_o} : 32'h0000_0000;

  // Configuration fields
  wire  [1:0] run_sel   = lock_cfg[RUN_SEL_HI:RUN_SEL_LO];
  wire        low_range = lock_cfg[WIN_RANGE_B];
  wire        ld_dis    = lock_cfg[LD_DIS_B];
  wire  [1:0] sync_mode = sync_dly[SYNC_HI:SYNC_LO];
  wire  [7:0] win_th    = low_range ? WIN_LO : WIN_HI;
  wire  [7:0] loss_th   = low_range ? LOSS_LO : LOSS_HI;
  wire  [7:0] target    = run_target(run_sel);

  assign pready_o = psel_i && penable_i;

  // Read data captured in setup so the access phase sees a flop
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_mux;
      pslverr_o <= !hit_any;
    end
  end

  // Control register writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_cfg <= LOCK_CFG_RST;
      sync_dly <= SYNC_DLY_RST;
      abl_cfg  <= ABL_RST;
      irq_mask <= 2'h0;
    end else if (wr_acc) begin
      if (hit_lock) lock_cfg <= pwdata_i[7:0] & 8'h78;
      if (hit_sync) sync_dly <= pwdata_i[7:0];
      if (hit_abl)  abl_cfg  <= pwdata_i[1:0];
      if (hit_mask) irq_mask <= pwdata_i[1:0];
    end
  end

  assign abl_sel_o      = abl_cfg;
  assign abl_width_ps_o = abl_ps(abl_cfg);
  assign ref_delay_o    = sync_dly[RDLY_HI:RDLY_LO];
  assign fb_delay_o     = sync_dly[FDLY_HI:FDLY_LO];

  // Edge spacing measurement; a cycle ends when both edges are seen
  plldc_gap_t next_gap_state;
  logic       cyc_done;
  always_comb begin
    next_gap_state = gap_state;
    cyc_done       = 1'b0;
    case (gap_state)
      GAP_IDLE: begin
        if (ref_edge_i && fb_edge_i) cyc_done = 1'b1;
        else if (ref_edge_i)         next_gap_state = GAP_WAIT_FB;
        else if (fb_edge_i)          next_gap_state = GAP_WAIT_REF;
      end
      GAP_WAIT_FB: begin
        if (fb_edge_i) begin
          cyc_done       = 1'b1;
          next_gap_state = GAP_IDLE;
        end
      end
      GAP_WAIT_REF: begin
        if (ref_edge_i) begin
          cyc_done       = 1'b1;
          next_gap_state = GAP_IDLE;
        end
      end
      default: next_gap_state = GAP_IDLE;
    endcase
  end

  wire  [7:0] gap       = (gap_state == GAP_IDLE) ? 8'h00 : gap_cnt;
  wire        in_win    = gap < win_th;
  // loss threshold is wider than the window
  wire        over_loss = gap > loss_th;
  wire        run_full  = (run_cnt + 8'h01) >= target;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      gap_state <= GAP_IDLE;
      gap_cnt   <= 8'h00;
    end else begin
      gap_state <= next_gap_state;
      if (next_gap_state == GAP_IDLE || gap_state == GAP_IDLE) gap_cnt <= 8'h01;
      else if (gap_cnt != GAP_MAX)                             gap_cnt <= gap_cnt + 8'h01;
    end
  end

  // Lock run counter and flag
  logic next_lock;
  logic [7:0] next_run;
  always_comb begin
    next_lock = lock_flag_o;
    next_run  = run_cnt;
    // disable bit / hold clear while disabled
    if (ld_dis) begin
      next_lock = 1'b0;
      next_run  = 8'h00;
    end else if (cyc_done && !lock_flag_o) begin
      if (!in_win)       next_run = 8'h00;
      else if (run_full) begin
        next_lock = 1'b1;
        next_run  = 8'h00;
      end else           next_run = run_cnt + 8'h01;
    end else if (cyc_done && over_loss) begin
      next_lock = 1'b0;
      next_run  = 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lock_flag_o <= 1'b0;
      run_cnt     <= 8'h00;
    end else begin
      lock_flag_o <= next_lock;
      run_cnt     <= next_run;
    end
  end

  // async reset passes the pin straight through, no clock needed
  assign div_async_rst_o = sync_i && (sync_mode == SYNC_ASYNC);

  // synchronous reset on the clock after the pin rises
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_q         <= 1'b0;
      div_sync_rst_o <= 1'b0;
    end else begin
      sync_q         <= sync_i;
      div_sync_rst_o <= sync_i && !sync_q && (sync_mode == SYNC_SYNC);
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  wire [1:0] evt    = {lock_flag_o && !next_lock, !lock_flag_o && next_lock};
  wire [1:0] w1c    = (wr_acc && hit_stat) ? pwdata_i[1:0] : 2'h0;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) irq_stat <= 2'h0;
    else          irq_stat <= (irq_stat & ~w1c) | evt;
  end
  assign irq_o = |(irq_stat & irq_mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_abl_width;
    abl_width_ps_o == ((abl_sel_o == 2'h1) ? ABL_PS_1P3 :
                       (abl_sel_o == 2'h2) ? ABL_PS_6P0 : ABL_PS_2P9);
  endproperty
  a_abl_width: assert property (p_abl_width) else $error("Antibacklash width mismatch");

  property p_lock_run;
    $rose(lock_flag_o) |-> $past(cyc_done) && $past(in_win) && ($past(run_cnt) + 8'h01 >= $past(target));
  endproperty
  a_lock_run: assert property (p_lock_run) else $error("Lock set without full run");

  property p_win_break;
    cyc_done && !in_win && !lock_flag_o |=> run_cnt == 8'h00 && !lock_flag_o;
  endproperty
  a_win_break: assert property (p_win_break) else $error("Out-of-window cycle kept run");

  property p_hold;
    lock_flag_o && !ld_dis && !(cyc_done && over_loss) |=> lock_flag_o;
  endproperty
  a_hold: assert property (p_hold) else $error("Lock dropped without loss");

  property p_disable;
    ld_dis |=> !lock_flag_o;
  endproperty
  a_disable: assert property (p_disable) else $error("Lock set while disabled");

  property p_dis_clear;
    ld_dis [*2] |-> run_cnt == 8'h00 && !lock_flag_o;
  endproperty
  a_dis_clear: assert property (p_dis_clear) else $error("Run count not cleared");

  property p_sync_rst;
    sync_i && !$past(sync_i) && sync_mode == SYNC_SYNC |=> div_sync_rst_o ##1 !div_sync_rst_o;
  endproperty
  a_sync_rst: assert property (p_sync_rst) else $error("Sync reset pulse wrong");

  property p_async_rst;
    div_async_rst_o |-> sync_i && sync_dly[SYNC_HI:SYNC_LO] == SYNC_ASYNC;
  endproperty
  a_async_rst: assert property (p_async_rst) else $error("Async reset out of mode");

  property p_delay;
    wr_acc && hit_sync |=> ref_delay_o == $past(pwdata_i[5:3]) && fb_delay_o == $past(pwdata_i[2:0]);
  endproperty
  a_delay: assert property (p_delay) else $error("Path delay not written");

  property p_run_step;
    cyc_done && in_win && !lock_flag_o && !ld_dis && !run_full
      |=> run_cnt == $past(run_cnt) + 8'h01;
  endproperty
  a_run_step: assert property (p_run_step) else $error("Run count did not advance");

  property p_loss_drop;
    lock_flag_o && !ld_dis && cyc_done && over_loss |=> !lock_flag_o;
  endproperty
  a_loss_drop: assert property (p_loss_drop) else $error("Lock kept past loss threshold");

  property p_sync_once;
    div_sync_rst_o |=> !div_sync_rst_o;
  endproperty
  a_sync_once: assert property (p_sync_once) else $error("Sync reset wider than one cycle");

  property p_sync_mode;
    div_sync_rst_o |-> $past(sync_mode == SYNC_SYNC) && $past(sync_i);
  endproperty
  a_sync_mode: assert property (p_sync_mode) else $error("Sync reset outside its mode");

  property p_abl_hold;
    !(wr_acc && hit_abl) |=> $stable(abl_sel_o);
  endproperty
  a_abl_hold: assert property (p_abl_hold) else $error("Antibacklash code changed unwritten");

  property p_delay_hold;
    !(wr_acc && hit_sync) |=> $stable(ref_delay_o) && $stable(fb_delay_o);
  endproperty
  a_delay_hold: assert property (p_delay_hold) else $error("Path delay changed unwritten");

  c_lock:   cover property ($rose(lock_flag_o));
  c_loss:   cover property ($fell(lock_flag_o) && !ld_dis);
  c_sync:   cover property (div_sync_rst_o);
  c_irq:    cover property (irq_o);

endmodule

// ### bench/plldc_edge_src.sv
module plldc_edge_src (
  // Clock
  input  wire logic clk_i,
  // Detector edge pulses
  output logic      ref_edge_o,
  output logic      fb_edge_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    ref_edge_o = 1'b0;
    fb_edge_o  = 1'b0;
  end

  // Reference leads, feedback trails by gap clocks; gap 0 is coincident
  task automatic send(input int gap, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ref_edge_o <= 1'b1;
      fb_edge_o  <= (gap == 0);
      @(posedge clk_i);
      ref_edge_o <= 1'b0;
      fb_edge_o  <= (gap == 1);
      if (gap > 1) begin
        repeat (gap - 1) @(posedge clk_i);
        fb_edge_o <= 1'b1;
      end
      if (gap > 0) begin
        @(posedge clk_i);
        fb_edge_o <= 1'b0;
      end
      @(posedge clk_i);
    end
  endtask
endmodule

// ### bench/tb_top.sv
module tb_top import plldc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        sync    = 1'b0;
  logic        pready, pslverr, ref_edge, fb_edge, async_rst, sync_rst, lock, irq, rerr;
  logic [31:0] prdata, rdat;
  logic [1:0]  abl_sel;
  logic [12:0] abl_ps;
  logic [2:0]  ref_dly, fb_dly;
  int          num_errors = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  logic [12:0] abl_tbl [4] = '{ABL_PS_2P9, ABL_PS_1P3, ABL_PS_6P0, ABL_PS_2P9};
  int          run_tbl [4] = '{5, 16, 64, 255};

  plldc_top DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .ref_edge_i(ref_edge), .fb_edge_i(fb_edge),
    .sync_i(sync), .abl_sel_o(abl_sel), .abl_width_ps_o(abl_ps), .ref_delay_o(ref_dly),
    .fb_delay_o(fb_dly), .div_async_rst_o(async_rst), .div_sync_rst_o(sync_rst),
    .lock_flag_o(lock), .irq_o(irq)
  );
  plldc_edge_src SRC (.clk_i(clk_i), .ref_edge_o(ref_edge), .fb_edge_o(fb_edge));

  always #20 clk_i = ~clk_i;

  // Whole run needs about 2000 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      num_errors++;
      test_done();
    end
  end

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      t++;
    end while (pready !== 1'b1);
    chk(t, 1, "wait states");
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic x);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, e, "read data");
    chk(rerr, x, "slave error");
  endtask

  task automatic lk(input int gap, input int n, input logic e);
    SRC.send(gap, n);
    chk(lock, e, "lock flag");
  endtask

  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(12'h060, 0, 0);
    rd(12'h064, 0, 0);
    chk(abl_ps, ABL_PS_2P9, "width");
    rd(12'h400, 0, 1);
    rd(12'h062, 0, 1);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      wr(12'h080, 32'(i));
      chk(abl_ps, abl_tbl[i], "width");
      chk(abl_sel, i[1:0], "code");
    end
    wr(12'h064, 32'h0000_002A);
    chk(ref_dly, 3'h5, "ref delay");
    chk(fb_dly, 3'h2, "fb delay");
    for (int m = 0; m < 4; m++) begin
      wr(12'h064, {24'h00_0000, m[1:0], 6'h00});
      sync <= 1'b1;
      for (int k = 1; k < 5; k++) begin
        @(posedge clk_i);
        chk(sync_rst, m == 2 && k == 2, "sync reset");
        chk(async_rst, m == 1, "async reset");
      end
      sync <= 1'b0;
    end
    $display("control test done");
    wr(12'h064, 32'h0000_0000);
    wr(12'h088, 32'h0000_0003);
    lk(2, 4, 0);
    lk(2, 1, 1);
    rd(12'h084, 1, 0);
    wr(12'h084, 32'h0000_0001);
    chk(irq, 0, "irq clear");
    lk(5, 3, 1);
    lk(7, 1, 0);
    chk(irq, 1, "irq loss");
    wr(12'h088, 32'h0000_0000);
    chk(irq, 0, "irq masked");
    wr(12'h084, 32'h0000_0002);
    rd(12'h084, 0, 0);
    wr(12'h060, 32'h0000_0010);
    lk(1, 5, 0);
    lk(0, 5, 1);
    lk(2, 1, 1);
    lk(3, 1, 0);
    $display("window test done");
    for (int i = 0; i < 4; i++) begin
      wr(12'h060, 32'(i << 5));
      lk(2, run_tbl[i] - 1, 0);
      lk(2, 1, 1);
      lk(7, 1, 0);
    end
    $display("run length test done");
    wr(12'h060, 32'h0000_0000);
    lk(2, 5, 1);
    wr(12'h060, 32'h0000_0008);
    rd(12'h060, 32'h0000_0008, 0);
    @(posedge clk_i);
    chk(lock, 0, "disabled");
    lk(2, 5, 0);
    wr(12'h060, 32'h0000_0000);
    lk(2, 4, 0);
    rd(12'h08C, 32'h0000_0008, 0);
    lk(2, 1, 1);
    rd(12'h08C, 32'h0000_0001, 0);
    $display("disable test done");
    test_done();
  end
endmodule
